// ---- src/ltp_pkg.sv ----
// Constants, register map and carrier types of the test pattern formatter
package ltp_pkg;
   // Channel count and word widths
   localparam int LTP_NCH = 4;
   localparam int LTP_RES = 14;
   localparam int LTP_WORD = 16;
   localparam int LTP_WORD_SHORT = 12;
   localparam int LTP_PAD = LTP_WORD - LTP_RES;
   localparam int LTP_TRUNC = LTP_WORD - LTP_WORD_SHORT;

   // Serial register port framing
   localparam int LTP_ADDR_W = 13;
   localparam int LTP_INSTR_BITS = 16;
   localparam int LTP_DATA_BITS = 8;
   localparam int LTP_FRAME_BITS = LTP_INSTR_BITS + LTP_DATA_BITS;
   localparam int LTP_RW_POS = 14;

   // Register offsets
   localparam logic [12:0] LTP_ADDR_TEST_MODE = 13'h000D;
   localparam logic [12:0] LTP_ADDR_USER1_A = 13'h0019;
   localparam logic [12:0] LTP_ADDR_USER1_B = 13'h001A;
   localparam logic [12:0] LTP_ADDR_USER2_A = 13'h001B;
   localparam logic [12:0] LTP_ADDR_USER2_B = 13'h001C;
   localparam logic [12:0] LTP_ADDR_OUT_MODE = 13'h0014;
   localparam logic [12:0] LTP_ADDR_OUT_PHASE = 13'h0016;
   localparam logic [12:0] LTP_ADDR_SER_CTRL = 13'h0021;

   // Field positions
   localparam int LTP_TM_RST_LONG_BIT = 4;
   localparam int LTP_TM_RST_SHORT_BIT = 5;
   localparam int LTP_OM_OFFSET_BIN_BIT = 0;
   localparam int LTP_SC_LSB_FIRST_BIT = 0;
   localparam int LTP_SC_WORD12_BIT = 1;
   localparam int LTP_SC_ONE_LANE_BIT = 2;

   // Reset values
   localparam logic [7:0] LTP_TM_RESET = 8'h00;
   localparam logic [7:0] LTP_USER_RESET = 8'h00;
   localparam logic [7:0] LTP_OM_RESET = 8'h00;
   localparam logic [7:0] LTP_PHASE_RESET = 8'h03;
   localparam logic [7:0] LTP_SC_RESET = 8'h00;

   // Test mode codes
   localparam logic [3:0] LTP_TM_OFF = 4'h0;
   localparam logic [3:0] LTP_TM_MID = 4'h1;
   localparam logic [3:0] LTP_TM_POS_FS = 4'h2;
   localparam logic [3:0] LTP_TM_NEG_FS = 4'h3;
   localparam logic [3:0] LTP_TM_CHECKER = 4'h4;
   localparam logic [3:0] LTP_TM_LONG_PRBS = 4'h5;
   localparam logic [3:0] LTP_TM_SHORT_PRBS = 4'h6;
   localparam logic [3:0] LTP_TM_WORD_TOGGLE = 4'h7;
   localparam logic [3:0] LTP_TM_USER = 4'h8;
   localparam logic [3:0] LTP_TM_BIT_TOGGLE = 4'h9;
   localparam logic [3:0] LTP_TM_SYNC = 4'hA;
   localparam logic [3:0] LTP_TM_ONE_BIT = 4'hB;
   localparam logic [3:0] LTP_TM_MIXED = 4'hC;

   // Pattern words, 16-bit and 12-bit forms (offset binary where formatted)
   localparam logic [15:0] LTP_P16_MID = 16'h8000;
   localparam logic [15:0] LTP_P16_POS_FS = 16'hFFFC;
   localparam logic [15:0] LTP_P16_ZERO = 16'h0000;
   localparam logic [15:0] LTP_P16_CHK_A = 16'hAAA8;
   localparam logic [15:0] LTP_P16_CHK_B = 16'h5554;
   localparam logic [15:0] LTP_P16_ONES = 16'hFFFC;
   localparam logic [15:0] LTP_P16_SYNC = 16'h01FC;
   localparam logic [15:0] LTP_P16_MIXED = 16'hA19C;
   localparam logic [11:0] LTP_P12_MID = 12'h800;
   localparam logic [11:0] LTP_P12_POS_FS = 12'hFFF;
   localparam logic [11:0] LTP_P12_ZERO = 12'h000;
   localparam logic [11:0] LTP_P12_CHK_A = 12'hAAA;
   localparam logic [11:0] LTP_P12_CHK_B = 12'h555;
   localparam logic [11:0] LTP_P12_ONES = 12'hFFF;
   localparam logic [11:0] LTP_P12_SYNC = 12'h03F;
   localparam logic [11:0] LTP_P12_MIXED = 12'hA33;

   // Pseudorandom generators: lengths and tap positions
   localparam int LTP_SHORT_LEN = 9;
   localparam int LTP_SHORT_TAP = 4;
   localparam int LTP_LONG_LEN = 23;
   localparam int LTP_LONG_TAP = 17;

   // Bit timing: one bit period is split into phase steps of the clock
   localparam int LTP_PHASE_STEP_DEG = 60;
   localparam int LTP_TICKS_PER_BIT = 360 / LTP_PHASE_STEP_DEG;
   localparam int LTP_DCO_TICKS = 2 * LTP_TICKS_PER_BIT;
   localparam int LTP_STRAP_WAIT = 3;

   typedef struct packed {
      logic [LTP_NCH-1:0][LTP_RES-1:0] sample;
   } ltp_conv_t;

   typedef struct packed {
      logic [3:0] mode;
      logic word12;
      logic one_lane;
      logic lsb_first;
      logic offset_bin;
      logic [3:0] phase;
   } ltp_cfg_t;
endpackage

// ---- src/ltp_formatter.sv ----
// Test pattern generator, output formatter, serializer and register port
`timescale 1ns/1ps
module ltp_formatter
   import ltp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire ltp_conv_t conv_in,
   output logic conv_take,
   input wire logic serial_select_n,
   input wire logic serial_clock_pattern_strap_pin,
   input wire logic serial_io_lane_strap_pin_in,
   output logic serial_io_lane_strap_pin_out,
   output logic serial_io_lane_strap_pin_oe,
   output logic [LTP_NCH-1:0] lane_a_pair,
   output logic [LTP_NCH-1:0] lane_b_pair,
   output logic word_frame_clock,
   output logic bit_capture_clock
);
   // Pin synchronisers: index 0 select, 1 serial clock, 2 serial data
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic [2:0] pin_last;
   logic sel_n;
   logic sclk_rise;
   logic sclk_fall;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_meta <= 3'h1;
         pin_sync <= 3'h1;
         pin_last <= 3'h1;
      end else begin
         pin_meta <= {serial_io_lane_strap_pin_in, serial_clock_pattern_strap_pin,
                      serial_select_n};
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   assign sel_n = pin_sync[0];
   assign sclk_rise = pin_sync[1] & ~pin_last[1];
   assign sclk_fall = ~pin_sync[1] & pin_last[1];

   // Strap capture shortly after reset release
   logic [1:0] strap_cnt;
   logic strap_done;
   logic pin_mode;
   logic strap_two_lane;
   logic strap_fixed;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         strap_cnt <= 2'h0;
         strap_done <= 1'b0;
         pin_mode <= 1'b0;
         strap_two_lane <= 1'b1;
         strap_fixed <= 1'b0;
      end else if (!strap_done) begin
         if (strap_cnt == 2'(LTP_STRAP_WAIT - 1)) begin
            strap_done <= 1'b1;
            pin_mode <= sel_n;
            strap_two_lane <= pin_sync[2];
            strap_fixed <= pin_sync[1] & sel_n;
         end else begin
            strap_cnt <= strap_cnt + 2'h1;
         end
      end
   end

   // Serial register port
   logic [4:0] spi_cnt;
   logic [15:0] spi_shift;
   logic spi_rd;
   logic [12:0] spi_addr;
   logic spi_wr;
   logic [7:0] spi_wdata;
   logic [7:0] rd_byte;
   logic [4:0] rd_pos;

   assign spi_wr = sclk_rise && !sel_n && strap_done && !spi_rd
                   && spi_cnt == 5'(LTP_FRAME_BITS - 1);
   assign spi_wdata = {spi_shift[LTP_DATA_BITS-2:0], pin_sync[2]};
   assign rd_pos = 5'(LTP_FRAME_BITS - 1) - spi_cnt;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         spi_cnt <= 5'h0;
         spi_shift <= 16'h0000;
         spi_rd <= 1'b0;
         spi_addr <= 13'h0000;
      end else if (sel_n || !strap_done) begin
         spi_cnt <= 5'h0;
      end else if (sclk_rise && spi_cnt < 5'(LTP_FRAME_BITS)) begin
         spi_shift <= {spi_shift[14:0], pin_sync[2]};
         spi_cnt <= spi_cnt + 5'h1;
         if (spi_cnt == 5'(LTP_INSTR_BITS - 1)) begin
            spi_rd <= spi_shift[LTP_RW_POS];
            spi_addr <= {spi_shift[LTP_ADDR_W-2:0], pin_sync[2]};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         serial_io_lane_strap_pin_out <= 1'b0;
         serial_io_lane_strap_pin_oe <= 1'b0;
      end else if (sel_n) begin
         serial_io_lane_strap_pin_oe <= 1'b0;
      end else if (sclk_fall) begin
         if (spi_rd && spi_cnt >= 5'(LTP_INSTR_BITS) && spi_cnt < 5'(LTP_FRAME_BITS)) begin
            serial_io_lane_strap_pin_oe <= 1'b1;
            serial_io_lane_strap_pin_out <= rd_byte[rd_pos[2:0]];
         end else begin
            serial_io_lane_strap_pin_oe <= 1'b0;
         end
      end
   end

   // Register file
   logic [7:0] output_test_mode_control;
   logic [7:0] user_pattern_word1_byte_a;
   logic [7:0] user_pattern_word1_byte_b;
   logic [7:0] user_pattern_word2_byte_a;
   logic [7:0] user_pattern_word2_byte_b;
   logic [7:0] output_mode;
   logic [7:0] output_phase;
   logic [7:0] serial_control;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         output_test_mode_control <= LTP_TM_RESET;
         user_pattern_word1_byte_a <= LTP_USER_RESET;
         user_pattern_word1_byte_b <= LTP_USER_RESET;
         user_pattern_word2_byte_a <= LTP_USER_RESET;
         user_pattern_word2_byte_b <= LTP_USER_RESET;
         output_mode <= LTP_OM_RESET;
         output_phase <= LTP_PHASE_RESET;
         serial_control <= LTP_SC_RESET;
      end else if (spi_wr) begin
         case (spi_addr)
            LTP_ADDR_TEST_MODE: output_test_mode_control <= spi_wdata;
            LTP_ADDR_USER1_A: user_pattern_word1_byte_a <= spi_wdata;
            LTP_ADDR_USER1_B: user_pattern_word1_byte_b <= spi_wdata;
            LTP_ADDR_USER2_A: user_pattern_word2_byte_a <= spi_wdata;
            LTP_ADDR_USER2_B: user_pattern_word2_byte_b <= spi_wdata;
            LTP_ADDR_OUT_MODE: output_mode <= spi_wdata;
            LTP_ADDR_OUT_PHASE: output_phase <= spi_wdata;
            LTP_ADDR_SER_CTRL: serial_control <= spi_wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      case (spi_addr)
         LTP_ADDR_TEST_MODE: rd_byte = output_test_mode_control;
         LTP_ADDR_USER1_A: rd_byte = user_pattern_word1_byte_a;
         LTP_ADDR_USER1_B: rd_byte = user_pattern_word1_byte_b;
         LTP_ADDR_USER2_A: rd_byte = user_pattern_word2_byte_a;
         LTP_ADDR_USER2_B: rd_byte = user_pattern_word2_byte_b;
         LTP_ADDR_OUT_MODE: rd_byte = output_mode;
         LTP_ADDR_OUT_PHASE: rd_byte = output_phase;
         LTP_ADDR_SER_CTRL: rd_byte = serial_control;
         default: rd_byte = 8'h00;
      endcase
   end

   // Effective configuration from registers or straps
   ltp_cfg_t cfg_live;
   ltp_cfg_t cfg_word;

   always_comb begin
      cfg_live.mode = output_test_mode_control[3:0];
      cfg_live.word12 = serial_control[LTP_SC_WORD12_BIT];
      cfg_live.one_lane = serial_control[LTP_SC_ONE_LANE_BIT];
      cfg_live.lsb_first = serial_control[LTP_SC_LSB_FIRST_BIT];
      cfg_live.offset_bin = output_mode[LTP_OM_OFFSET_BIN_BIT];
      cfg_live.phase = output_phase[3:0];
      if (pin_mode) begin
         cfg_live.mode = strap_fixed ? LTP_TM_ONE_BIT : LTP_TM_OFF;
         cfg_live.one_lane = ~strap_two_lane;
         cfg_live.word12 = 1'b0;
      end
   end

   // Pseudorandom generators
   function automatic logic [LTP_SHORT_LEN+LTP_RES-1:0] run_short(
      input logic [LTP_SHORT_LEN-1:0] s);
      logic [LTP_SHORT_LEN-1:0] st;
      logic [LTP_RES-1:0] bits;
      st = s;
      bits = '0;
      for (int i = 0; i < LTP_RES; i++) begin
         bits = {bits[LTP_RES-2:0], st[LTP_SHORT_LEN-1]};
         st = {st[LTP_SHORT_LEN-2:0], st[LTP_SHORT_LEN-1] ^ st[LTP_SHORT_TAP]};
      end
      return {st, bits};
   endfunction

   function automatic logic [LTP_LONG_LEN+LTP_RES-1:0] run_long(
      input logic [LTP_LONG_LEN-1:0] s);
      logic [LTP_LONG_LEN-1:0] st;
      logic [LTP_RES-1:0] bits;
      st = s;
      bits = '0;
      for (int i = 0; i < LTP_RES; i++) begin
         bits = {bits[LTP_RES-2:0], st[LTP_LONG_LEN-1]};
         st = {st[LTP_LONG_LEN-2:0], st[LTP_LONG_LEN-1] ^ st[LTP_LONG_TAP]};
      end
      return {st, bits};
   endfunction

   logic [LTP_SHORT_LEN-1:0] short_prbs;
   logic [LTP_LONG_LEN-1:0] long_prbs;
   logic [LTP_SHORT_LEN+LTP_RES-1:0] short_run;
   logic [LTP_LONG_LEN+LTP_RES-1:0] long_run;
   logic word_end;
   logic alt;

   assign short_run = run_short(short_prbs);
   assign long_run = run_long(long_prbs);

   always_ff @(posedge core_clk) begin
      if (rst || output_test_mode_control[LTP_TM_RST_SHORT_BIT]) begin
         short_prbs <= '1;
      end else if (word_end && cfg_live.mode == LTP_TM_SHORT_PRBS) begin
         short_prbs <= short_run[LTP_SHORT_LEN+LTP_RES-1:LTP_RES];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || output_test_mode_control[LTP_TM_RST_LONG_BIT]) begin
         long_prbs <= '1;
      end else if (word_end && cfg_live.mode == LTP_TM_LONG_PRBS) begin
         long_prbs <= long_run[LTP_LONG_LEN+LTP_RES-1:LTP_RES];
      end
   end

   // Word alternation for two-word patterns
   always_ff @(posedge core_clk) begin
      if (rst) begin
         alt <= 1'b0;
      end else if (word_end) begin
         alt <= ~alt;
      end
   end

   // Builds the 16-bit word of one channel, MSB aligned
   function automatic logic [15:0] build_word(input ltp_cfg_t c, input logic a,
      input logic [LTP_RES-1:0] conv, input logic [LTP_RES-1:0] sp,
      input logic [LTP_RES-1:0] lp, input logic [15:0] u1, input logic [15:0] u2);
      logic [15:0] w16;
      logic [11:0] w12;
      logic fmt;
      logic raw;
      w16 = LTP_P16_ZERO;
      w12 = LTP_P12_ZERO;
      fmt = 1'b0;
      raw = 1'b0;
      case (c.mode)
         LTP_TM_OFF: begin w16 = {conv, LTP_PAD'(0)}; fmt = 1'b1; raw = 1'b1; end
         LTP_TM_MID: begin w16 = LTP_P16_MID; w12 = LTP_P12_MID; fmt = 1'b1; end
         LTP_TM_POS_FS: begin w16 = LTP_P16_POS_FS; w12 = LTP_P12_POS_FS; fmt = 1'b1; end
         LTP_TM_NEG_FS: begin fmt = 1'b1; end
         LTP_TM_CHECKER: begin
            w16 = a ? LTP_P16_CHK_B : LTP_P16_CHK_A;
            w12 = a ? LTP_P12_CHK_B : LTP_P12_CHK_A;
         end
         LTP_TM_LONG_PRBS: begin w16 = {lp, LTP_PAD'(0)}; fmt = 1'b1; raw = 1'b1; end
         LTP_TM_SHORT_PRBS: begin w16 = {sp, LTP_PAD'(0)}; fmt = 1'b1; raw = 1'b1; end
         LTP_TM_WORD_TOGGLE: begin
            w16 = a ? LTP_P16_ZERO : LTP_P16_ONES;
            w12 = a ? LTP_P12_ZERO : LTP_P12_ONES;
         end
         LTP_TM_USER: begin
            w16 = a ? u2 : u1;
            w12 = w16[15:LTP_TRUNC];
         end
         LTP_TM_BIT_TOGGLE: begin w16 = LTP_P16_CHK_A; w12 = LTP_P12_CHK_A; end
         LTP_TM_SYNC: begin w16 = LTP_P16_SYNC; w12 = LTP_P12_SYNC; end
         LTP_TM_ONE_BIT: begin w16 = LTP_P16_MID; w12 = LTP_P12_MID; end
         LTP_TM_MIXED: begin w16 = LTP_P16_MIXED; w12 = LTP_P12_MIXED; end
         default: ;
      endcase
      if (c.word12 && !raw) begin
         w16 = {w12, LTP_TRUNC'(0)};
      end
      if (c.word12 && raw) begin
         w16 = {w16[15:LTP_TRUNC], LTP_TRUNC'(0)};
      end
      if (fmt && !c.offset_bin) begin
         w16[15] = ~w16[15];
      end
      return w16;
   endfunction

   // Orders the active bits in transmit order, position 0 first
   function automatic logic [15:0] order_word(input logic [15:0] w, input logic w12,
      input logic lsb);
      logic [15:0] seq;
      seq = '0;
      for (int i = 0; i < LTP_WORD; i++) begin
         if (!lsb) begin
            seq[i] = w[LTP_WORD-1-i];
         end else if (w12) begin
            seq[i] = (i < LTP_WORD_SHORT) ? w[LTP_TRUNC+i] : 1'b0;
         end else begin
            seq[i] = w[i];
         end
      end
      return seq;
   endfunction

   // Serializer timing
   logic [2:0] tick;
   logic [4:0] bit_idx;
   logic [3:0] dco_pos;
   logic [4:0] bits_per_lane;
   logic [LTP_NCH-1:0][15:0] seq_word;

   assign bits_per_lane = cfg_word.one_lane
                          ? (cfg_word.word12 ? 5'(LTP_WORD_SHORT) : 5'(LTP_WORD))
                          : (cfg_word.word12 ? 5'(LTP_WORD_SHORT / 2) : 5'(LTP_WORD / 2));
   assign word_end = tick == 3'(LTP_TICKS_PER_BIT - 1) && bit_idx == bits_per_lane - 5'h1;
   assign conv_take = word_end;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tick <= 3'h0;
         bit_idx <= 5'h0;
         dco_pos <= 4'h0;
      end else begin
         dco_pos <= (word_end || dco_pos == 4'(LTP_DCO_TICKS - 1)) ? 4'h0 : dco_pos + 4'h1;
         if (tick == 3'(LTP_TICKS_PER_BIT - 1)) begin
            tick <= 3'h0;
            bit_idx <= word_end ? 5'h0 : bit_idx + 5'h1;
         end else begin
            tick <= tick + 3'h1;
         end
      end
   end

   // configuration and words change at word end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_word <= '0;
         cfg_word.phase <= LTP_PHASE_RESET[3:0];
         seq_word <= '0;
      end else if (word_end) begin
         cfg_word <= cfg_live;
         for (int ch = 0; ch < LTP_NCH; ch++) begin
            seq_word[ch] <= order_word(build_word(cfg_live, alt, conv_in.sample[ch],
               short_run[LTP_RES-1:0], long_run[LTP_RES-1:0],
               {user_pattern_word1_byte_b, user_pattern_word1_byte_a},
               {user_pattern_word2_byte_b, user_pattern_word2_byte_a}),
               cfg_live.word12, cfg_live.lsb_first);
         end
      end
   end

   // Lane outputs, frame clock and phased data clock
   logic [3:0] dco_rel;
   logic [3:0] phase_lim;

   assign phase_lim = (cfg_word.phase > 4'(LTP_DCO_TICKS - 1)) ? 4'(LTP_DCO_TICKS - 1)
                      : cfg_word.phase;
   assign dco_rel = (dco_pos >= phase_lim) ? dco_pos - phase_lim
                    : dco_pos + 4'(LTP_DCO_TICKS) - phase_lim;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         lane_a_pair <= '0;
         lane_b_pair <= '0;
         word_frame_clock <= 1'b0;
         bit_capture_clock <= 1'b0;
      end else begin
         bit_capture_clock <= dco_rel < 4'(LTP_TICKS_PER_BIT);
         word_frame_clock <= bit_idx < (bits_per_lane >> 1);
         for (int ch = 0; ch < LTP_NCH; ch++) begin
            // padding zeros sit in the word tail, but at its head for LSB-first 16-bit words
            if (cfg_word.one_lane) begin
               lane_a_pair[ch] <= seq_word[ch][bit_idx[3:0]];
               lane_b_pair[ch] <= 1'b0;
            end else begin
               lane_b_pair[ch] <= seq_word[ch][{bit_idx[2:0], 1'b0}];
               lane_a_pair[ch] <= seq_word[ch][{bit_idx[2:0], 1'b1}];
            end
         end
      end
   end
endmodule

// ---- test/ltp_checker.sv ----
// Port assertions for the test pattern formatter
`timescale 1ns/1ps
module ltp_checker
   import ltp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic conv_take,
   input wire logic serial_select_n,
   input wire logic serial_io_lane_strap_pin_oe,
   input wire logic [LTP_NCH-1:0] lane_a_pair,
   input wire logic [LTP_NCH-1:0] lane_b_pair,
   input wire logic word_frame_clock,
   input wire logic bit_capture_clock
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   property p_dco_hi; $rose(bit_capture_clock) |=> bit_capture_clock [*5] ##1 !bit_capture_clock; endproperty
   a_dco_hi: assert property (p_dco_hi) else $error("data clock high phase wrong");
   property p_dco_lo; $fell(bit_capture_clock) |=> !bit_capture_clock [*5] ##1 bit_capture_clock; endproperty
   a_dco_lo: assert property (p_dco_lo) else $error("data clock low phase wrong");
   property p_lane_a; $changed(lane_a_pair) |=> $stable(lane_a_pair) [*5]; endproperty
   a_lane_a: assert property (p_lane_a) else $error("lane a bit too short");
   property p_lane_b; $changed(lane_b_pair) |=> $stable(lane_b_pair) [*5]; endproperty
   a_lane_b: assert property (p_lane_b) else $error("lane b bit too short");
   property p_frame; $rose(word_frame_clock) |=> word_frame_clock [*5]; endproperty
   a_frame: assert property (p_frame) else $error("frame pulse too short");
   property p_phase; $rose(word_frame_clock) |-> ##3 $changed(bit_capture_clock); endproperty
   a_phase: assert property (p_phase) else $error("data clock phase not default");
   property p_take; conv_take |-> ##[1:2] $rose(word_frame_clock); endproperty
   a_take: assert property (p_take) else $error("sample take off word edge");
   property p_oe; serial_select_n [*6] |-> !serial_io_lane_strap_pin_oe; endproperty
   a_oe: assert property (p_oe) else $error("readback driven while deselected");
endmodule
bind ltp_formatter ltp_checker chk_i (.core_clk, .rst, .conv_take, .serial_select_n,
   .serial_io_lane_strap_pin_oe, .lane_a_pair, .lane_b_pair, .word_frame_clock, .bit_capture_clock);

// ---- test/ltp_receiver.sv ----
// Lane receiver model: rebuilds channel 0 words between frame rises
`timescale 1ns/1ps
module ltp_receiver
   import ltp_pkg::*;
(
   input wire logic core_clk,
   input wire logic [LTP_NCH-1:0] lane_a_pair,
   input wire logic [LTP_NCH-1:0] lane_b_pair,
   input wire logic word_frame_clock,
   output logic [15:0] rx_word,
   output logic rx_ok
);
   logic frame_d = 1'b0;
   logic [2:0] cnt = 3'h0;
   logic [15:0] acc = 16'h0000;
   always_ff @(posedge core_clk) begin
      frame_d <= word_frame_clock;
      rx_ok <= word_frame_clock && !frame_d;
      if (word_frame_clock && !frame_d) begin
         rx_word <= acc;
         acc <= 16'h0000;
         cnt <= 3'h1;
      end else begin
         cnt <= (cnt == 3'h6) ? 3'h1 : cnt + 3'h1;
         if (cnt == 3'h3) acc <= {acc[13:0], lane_b_pair[0], lane_a_pair[0]};
      end
   end
endmodule

// ---- test/ltp_formatter_tb_top.sv ----
// Bench for the test pattern formatter
`timescale 1ns/1ps
module ltp_formatter_tb_top;
   import ltp_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic serial_select_n = 1'b0;
   logic serial_clock_pattern_strap_pin = 1'b0;
   logic sdi = 1'b0;
   ltp_conv_t conv_in = '0;
   logic conv_take, serial_io_lane_strap_pin_out, serial_io_lane_strap_pin_oe;
   logic word_frame_clock, bit_capture_clock, rx_ok;
   logic [LTP_NCH-1:0] lane_a_pair, lane_b_pair;
   logic [15:0] rx_word, w, w2;
   int fail_count = 0;
   int checks_done = 0;
   wire logic serial_io_lane_strap_pin_in;
   assign serial_io_lane_strap_pin_in = serial_io_lane_strap_pin_oe ? serial_io_lane_strap_pin_out : sdi;
   always #5 core_clk = ~core_clk;
   ltp_formatter dut (.core_clk, .rst, .conv_in, .conv_take, .serial_select_n,
      .serial_clock_pattern_strap_pin, .serial_io_lane_strap_pin_in, .serial_io_lane_strap_pin_out,
      .serial_io_lane_strap_pin_oe, .lane_a_pair, .lane_b_pair, .word_frame_clock, .bit_capture_clock);
   ltp_receiver rx (.core_clk, .lane_a_pair, .lane_b_pair, .word_frame_clock, .rx_word, .rx_ok);
   task automatic summarize();
      if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic xfer(input logic rw, input logic [12:0] a, input logic [7:0] d,
      output logic [7:0] q);
      logic [23:0] f;
      f = {rw, 2'b00, a, d};
      q = 8'h00;
      serial_select_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         #62.5 sdi = f[i];
         #62.5;
         if (i < 8) q[i] = serial_io_lane_strap_pin_in;
         serial_clock_pattern_strap_pin = 1'b1;
         #62.5 serial_clock_pattern_strap_pin = 1'b0;
      end
      #200 serial_select_n = 1'b1;
      #200;
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b0, a, d, q);
   endtask
   task automatic nxt(output logic [15:0] v);
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (rx_ok !== 1'b1 && n < 300);
      if (n >= 300) fail_count++;
      v = rx_word;
   endtask
   task automatic md(input logic [7:0] v);
      wr(LTP_ADDR_TEST_MODE, v);
      nxt(w);
      nxt(w);
   endtask
   task automatic pair(input logic [3:0] c, input logic [15:0] a, input logic [15:0] b);
      md({4'h0, c});
      nxt(w2);
      chk("pair", 16'((w === a && w2 === b) || (w === b && w2 === a)), 16'h0001);
   endtask
   task automatic t_data();
      nxt(w);
      nxt(w);
      chk("data", w, 16'hC8D0);
   endtask
   task automatic t_fixed();
      logic [3:0] c [7] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'hC};
      logic [15:0] e [7] = '{16'h0000, 16'h7FFC, 16'h8000, 16'hAAA8, 16'h01FC, 16'h8000, 16'hA19C};
      for (int i = 0; i < 7; i++) begin
         md({4'h0, c[i]});
         chk("fixed", w, e[i]);
      end
   endtask
   task automatic t_pair();
      logic [7:0] q;
      xfer(1'b1, LTP_ADDR_OUT_PHASE, 8'h00, q);
      chk("rd phase", {8'h00, q}, 16'h0003);
      wr(LTP_ADDR_USER1_A, 8'h34);
      xfer(1'b1, LTP_ADDR_USER1_A, 8'h00, q);
      chk("rd user", {8'h00, q}, 16'h0034);
      wr(LTP_ADDR_USER1_B, 8'h12);
      wr(LTP_ADDR_USER2_A, 8'hCD);
      wr(LTP_ADDR_USER2_B, 8'hAB);
      pair(LTP_TM_CHECKER, 16'hAAA8, 16'h5554);
      pair(LTP_TM_WORD_TOGGLE, 16'hFFFC, 16'h0000);
      pair(LTP_TM_USER, 16'h1234, 16'hABCD);
   endtask
   task automatic t_fmt();
      wr(LTP_ADDR_OUT_MODE, 8'h01);
      md({4'h0, LTP_TM_MID});
      chk("offset", w, 16'h8000);
      wr(LTP_ADDR_OUT_MODE, 8'h00);
      wr(LTP_ADDR_SER_CTRL, 8'h02);
      pair(LTP_TM_CHECKER, 16'h0AAA, 16'h0555);
      wr(LTP_ADDR_SER_CTRL, 8'h01);
      md({4'h0, LTP_TM_SYNC});
      chk("lsb", w, 16'h3F80);
      wr(LTP_ADDR_SER_CTRL, 8'h00);
   endtask
   task automatic t_prbs(input logic [7:0] hold, input logic [15:0] a, input logic [15:0] b);
      int n;
      n = 0;
      md(hold);
      wr(LTP_ADDR_TEST_MODE, hold & 8'h0F);
      nxt(w);
      do begin
         w2 = w;
         nxt(w);
         n++;
      end while (w === a && n < 20);
      chk("seed", w2, a);
      chk("next", w, b);
   endtask
   initial begin
      conv_in.sample = {LTP_NCH{14'h1234}};
      repeat (10) @(posedge core_clk);
      #1 rst = 1'b0;
      repeat (8) @(posedge core_clk);
      #1 serial_select_n = 1'b1;
      t_data();
      t_fixed();
      t_pair();
      t_fmt();
      t_prbs(8'h26, 16'h7F80, 16'h77C4);
      t_prbs(8'h15, 16'h7FFC, 16'h7F80);
      summarize();
   end
   initial begin
      #400000;
      fail_count++;
      summarize();
   end
endmodule
